// file: pkg/cci_defs.svh
`ifndef CCI_DEFS_SVH
`define CCI_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CCI_ADDR_CFG 8'h4D
`define CCI_ADDR_MASK 8'h4E
`define CCI_CFG_RESET 8'h00
`define CCI_MASK_RESET 8'h00
`define CCI_CFG_WMASK 8'hFB
`define CCI_MASK_WMASK 8'h3F
`define CCI_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCI_CFG_OSC 7
`define CCI_CFG_FREQ_HI 6
`define CCI_CFG_FREQ_LO 5
`define CCI_CFG_LOGIC_INH 4
`define CCI_CFG_INPUT_INH 3
`define CCI_CFG_IRQ_PULSE 1
`define CCI_CFG_RST_IGN 0
`define CCI_SRC_WIDTH 6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCI_MCLK_KHZ 100000
`define CCI_BASE_KHZ 1000
`define CCI_BASE_DIV (`CCI_MCLK_KHZ / `CCI_BASE_KHZ)
`define CCI_DIV_50K 5'd20
`define CCI_DIV_100K 5'd10
`define CCI_DIV_200K 5'd5
`define CCI_DIV_500K 5'd2
`define CCI_SCAN_DIV 8'd100
`define CCI_RELEASE_US 50
`define CCI_RELEASE_CYCLES (`CCI_RELEASE_US * `CCI_MCLK_KHZ / 1000)

// ----------------------------------------------------------------
// Serial link
// ----------------------------------------------------------------
`define CCI_I2C_ADDR 7'h34 // Slave address, value arbitrary
`define CCI_BITS_PER_BYTE 4'd8
`endif

// file: pkg/cci_pkg.sv
package cci_pkg;
  // Serial slave states, Gray coded along the usual path
  typedef enum logic [2:0] {
    CCI_IDLE = 3'h0,
    CCI_ADDR = 3'h1,
    CCI_AACK = 3'h3,
    CCI_RXB = 3'h2,
    CCI_WACK = 3'h6,
    CCI_RD = 3'h7,
    CCI_RACK = 3'h5
  } cci_i2c_state_t;
endpackage

// file: core/cci_i2c_slave.sv
`include "cci_defs.svh"

module cci_i2c_slave (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic sclIn, // Serial clock pin
  input wire logic sdaIn, // Serial data pin level
  input wire logic [7:0] regRdData, // Read data at regAddr
  output logic sdaOe, // Pull data line low
  output logic [7:0] regAddr, // Register pointer
  output logic [7:0] regWrData, // Write data
  output logic regWrStb // Write pulse
);
  logic sclS1_q, sclS2_q, sclS3_q, sdaS1_q, sdaS2_q, sdaS3_q;
  logic sclRise, sclFall, startC, stopC;
  cci_pkg::cci_i2c_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wrData_q, wrData_d;
  logic first_q, first_d, rw_q, rw_d, sdaOe_q, sdaOe_d, wrStb_q, wrStb_d;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sclS3_q <= 1'b1;
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
      sdaS3_q <= 1'b1;
    end else begin
      sclS1_q <= sclIn;
      sclS2_q <= sclS1_q;
      sclS3_q <= sclS2_q;
      sdaS1_q <= sdaIn;
      sdaS2_q <= sdaS1_q;
      sdaS3_q <= sdaS2_q;
    end
  end

  assign sclRise = sclS2_q & ~sclS3_q;
  assign sclFall = ~sclS2_q & sclS3_q;
  assign startC = sclS2_q & sclS3_q & ~sdaS2_q & sdaS3_q;
  assign stopC = sclS2_q & sclS3_q & sdaS2_q & ~sdaS3_q;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = wrStb_q ? ptr_q + 8'h01 : ptr_q;
    wrData_d = wrData_q;
    first_d = first_q;
    rw_d = rw_q;
    sdaOe_d = sdaOe_q;
    wrStb_d = 1'b0;
    if (stopC) begin
      st_d = cci_pkg::CCI_IDLE;
      sdaOe_d = 1'b0;
    end else if (startC) begin
      st_d = cci_pkg::CCI_ADDR;
      cnt_d = 4'h0;
      sdaOe_d = 1'b0;
    end else begin
      case (st_q)
        cci_pkg::CCI_ADDR, cci_pkg::CCI_RXB: begin
          if (sclRise && cnt_q < `CCI_BITS_PER_BYTE) begin
            sh_d = {sh_q[6:0], sdaS2_q};
            cnt_d = cnt_q + 4'h1;
          end else if (sclFall && cnt_q == `CCI_BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            if (st_q == cci_pkg::CCI_ADDR) begin
              if (sh_q[7:1] == `CCI_I2C_ADDR) begin
                rw_d = sh_q[0];
                sdaOe_d = 1'b1;
                st_d = cci_pkg::CCI_AACK;
              end else begin
                st_d = cci_pkg::CCI_IDLE;
              end
            end else begin
              if (first_q) begin
                ptr_d = sh_q;
              end else begin
                wrStb_d = 1'b1;
                wrData_d = sh_q;
              end
              first_d = 1'b0;
              sdaOe_d = 1'b1;
              st_d = cci_pkg::CCI_WACK;
            end
          end
        end
        cci_pkg::CCI_AACK: begin
          if (sclFall) begin
            if (rw_q) begin
              sh_d = regRdData;
              sdaOe_d = ~regRdData[7];
              cnt_d = 4'h1;
              ptr_d = ptr_q + 8'h01;
              st_d = cci_pkg::CCI_RD;
            end else begin
              sdaOe_d = 1'b0;
              first_d = 1'b1;
              st_d = cci_pkg::CCI_RXB;
            end
          end
        end
        cci_pkg::CCI_WACK: begin
          if (sclFall) begin
            sdaOe_d = 1'b0;
            st_d = cci_pkg::CCI_RXB;
          end
        end
        cci_pkg::CCI_RD: begin
          if (sclFall) begin
            if (cnt_q == `CCI_BITS_PER_BYTE) begin
              sdaOe_d = 1'b0;
              st_d = cci_pkg::CCI_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sdaOe_d = ~sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        cci_pkg::CCI_RACK: begin
          if (sclRise && sdaS2_q) begin
            st_d = cci_pkg::CCI_IDLE; // Master said no more
          end else if (sclFall) begin
            sh_d = regRdData;
            sdaOe_d = ~regRdData[7];
            cnt_d = 4'h1;
            ptr_d = ptr_q + 8'h01;
            st_d = cci_pkg::CCI_RD;
          end
        end
        default: st_d = cci_pkg::CCI_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cci_pkg::CCI_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      wrData_q <= 8'h00;
      first_q <= 1'b0;
      rw_q <= 1'b0;
      sdaOe_q <= 1'b0;
      wrStb_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      wrData_q <= wrData_d;
      first_q <= first_d;
      rw_q <= rw_d;
      sdaOe_q <= sdaOe_d;
      wrStb_q <= wrStb_d;
    end
  end

  assign sdaOe = sdaOe_q;
  assign regAddr = ptr_q;
  assign regWrData = wrData_q;
  assign regWrStb = wrStb_q;
endmodule // cci_i2c_slave

// file: core/cci_core_config.sv
`include "cci_defs.svh"

module cci_core_config #(
  parameter int unsigned RELEASE_CYCLES = `CCI_RELEASE_CYCLES // Interrupt release length
) (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic sclIn, // Serial clock pin
  input wire logic sdaIn, // Serial data pin level
  output logic sdaOut, // Serial data drive level
  output logic sdaOe, // Serial data drive enable
  input wire logic extReset_n, // External reset pin
  output logic deviceReset, // Device reset request
  output logic oscillator_on, // Internal oscillator enable
  output logic coreTick, // Core clock tick
  output logic scanTick, // Key and input scan tick
  input wire logic keypadLocked, // Keypad is locked
  input wire logic logicEventReq, // Logic output wants a record
  input wire logic inputEventReq, // General input wants a record
  output logic logicEventRecord, // Record logic event
  output logic inputEventRecord, // Record input event
  input wire logic [5:0] irqFlags, // Source flags, bit order as mask
  input wire logic irqClearTry, // Host tries to clear interrupt
  output logic irqOut, // Interrupt drive level
  output logic irqOe // Interrupt drive enable
);
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrStb;
  logic [7:0] cfg_q, cfg_d, mask_q, mask_d;
  logic rstS1_q, rstS2_q;
  logic devRst_q, devRst_d;
  logic [6:0] baseCnt_q, baseCnt_d;
  logic [4:0] coreCnt_q, coreCnt_d, coreDiv;
  logic [7:0] scanCnt_q, scanCnt_d;
  logic coreTick_q, coreTick_d, scanTick_q, scanTick_d;
  logic logicRec_q, logicRec_d, inputRec_q, inputRec_d;
  logic [12:0] relCnt_q, relCnt_d;
  logic irqOe_q, irqOe_d, pending;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Register read mux; unmapped and reserved bits read zero
  function automatic logic [7:0] regRead(input logic [7:0] a, input logic [7:0] c,
                                          input logic [7:0] m);
    logic [7:0] r;
    r = `CCI_UNMAPPED_READ;
    if (a == `CCI_ADDR_CFG) begin
      r = c & `CCI_CFG_WMASK;
    end else if (a == `CCI_ADDR_MASK) begin
      r = m & `CCI_MASK_WMASK;
    end
    return r;
  endfunction

  // Write target check
  function automatic logic regHit(input logic stb, input logic [7:0] a,
                                  input logic [7:0] target);
    return stb && (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  cci_i2c_slave uSlave (
    .mclk(mclk),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .regRdData(regRdData),
    .sdaOe(sdaOe),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStb(regWrStb)
  );

  assign regRdData = regRead(regAddr, cfg_q, mask_q);

  // ----------------------------------------------------------------
  // Configuration and mask registers
  // ----------------------------------------------------------------
  // Register writes
  always_comb begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    if (regHit(regWrStb, regAddr, `CCI_ADDR_CFG)) begin
      cfg_d = regWrData & `CCI_CFG_WMASK;
    end
    if (regHit(regWrStb, regAddr, `CCI_ADDR_MASK)) begin
      mask_d = regWrData & `CCI_MASK_WMASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `CCI_CFG_RESET;
      mask_q <= `CCI_MASK_RESET;
    end else begin
      cfg_q <= cfg_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // External reset pin
  // ----------------------------------------------------------------
  // Pin synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstS1_q <= 1'b1;
      rstS2_q <= 1'b1;
    end else begin
      rstS1_q <= extReset_n;
      rstS2_q <= rstS1_q;
    end
  end

  // Honour the pin only while not told to ignore it
  assign devRst_d = ~rstS2_q & ~cfg_q[`CCI_CFG_RST_IGN];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      devRst_q <= 1'b0;
    end else begin
      devRst_q <= devRst_d;
    end
  end

  // ----------------------------------------------------------------
  // Core clock and scan timing
  // ----------------------------------------------------------------
  // Divisor from 1 MHz base to core rate
  always_comb begin
    case (cfg_q[`CCI_CFG_FREQ_HI:`CCI_CFG_FREQ_LO])
      2'h0: coreDiv = `CCI_DIV_50K;
      2'h1: coreDiv = `CCI_DIV_100K;
      2'h2: coreDiv = `CCI_DIV_200K;
      default: coreDiv = `CCI_DIV_500K;
    endcase
  end

  // Base tick, core tick and scan tick counters
  always_comb begin
    baseCnt_d = baseCnt_q;
    coreCnt_d = coreCnt_q;
    scanCnt_d = scanCnt_q;
    coreTick_d = 1'b0;
    scanTick_d = 1'b0;
    if (!cfg_q[`CCI_CFG_OSC]) begin
      baseCnt_d = 7'h00;
      coreCnt_d = 5'h00;
    end else if (baseCnt_q == 7'(`CCI_BASE_DIV - 1)) begin
      baseCnt_d = 7'h00;
      if (coreCnt_q >= coreDiv - 5'h01) begin
        coreCnt_d = 5'h00;
        coreTick_d = 1'b1;
      end else begin
        coreCnt_d = coreCnt_q + 5'h01;
      end
    end else begin
      baseCnt_d = baseCnt_q + 7'h01;
    end
    if (coreTick_q) begin
      if (scanCnt_q == `CCI_SCAN_DIV - 8'h01) begin
        scanCnt_d = 8'h00;
        scanTick_d = 1'b1;
      end else begin
        scanCnt_d = scanCnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baseCnt_q <= 7'h00;
      coreCnt_q <= 5'h00;
      scanCnt_q <= 8'h00;
      coreTick_q <= 1'b0;
      scanTick_q <= 1'b0;
    end else begin
      baseCnt_q <= baseCnt_d;
      coreCnt_q <= coreCnt_d;
      scanCnt_q <= scanCnt_d;
      coreTick_q <= coreTick_d;
      scanTick_q <= scanTick_d;
    end
  end

  // ----------------------------------------------------------------
  // Event recording while locked
  // ----------------------------------------------------------------
  always_comb begin
    logicRec_d = logicEventReq & ~(keypadLocked & cfg_q[`CCI_CFG_LOGIC_INH]);
    inputRec_d = inputEventReq & ~(keypadLocked & cfg_q[`CCI_CFG_INPUT_INH]);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      logicRec_q <= 1'b0;
      inputRec_q <= 1'b0;
    end else begin
      logicRec_q <= logicRec_d;
      inputRec_q <= inputRec_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Each mask bit gates its own source flag
  assign pending = |(irqFlags & mask_q[`CCI_SRC_WIDTH-1:0]);

  // Release window after a clear that leaves a source pending
  always_comb begin
    relCnt_d = relCnt_q;
    if (irqClearTry && pending && cfg_q[`CCI_CFG_IRQ_PULSE] && relCnt_q == 13'h0000) begin
      relCnt_d = 13'(RELEASE_CYCLES);
    end else if (relCnt_q != 13'h0000) begin
      relCnt_d = relCnt_q - 13'h0001;
    end
    irqOe_d = pending && (relCnt_d == 13'h0000);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      relCnt_q <= 13'h0000;
      irqOe_q <= 1'b0;
    end else begin
      relCnt_q <= relCnt_d;
      irqOe_q <= irqOe_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdaOut = 1'b0; // Open drain, drives low only
  assign irqOut = 1'b0; // Open drain, drives low only
  assign irqOe = irqOe_q;
  assign deviceReset = devRst_q;
  assign oscillator_on = cfg_q[`CCI_CFG_OSC];
  assign coreTick = coreTick_q;
  assign scanTick = scanTick_q;
  assign logicEventRecord = logicRec_q;
  assign inputEventRecord = inputRec_q;
endmodule // cci_core_config

// file: tb/cci_core_config_asserts.sv
module cci_core_config_asserts #(
  parameter int unsigned RELEASE_CYCLES = 20 // Interrupt release length
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic extReset_n, // External reset pin
  input wire logic deviceReset, // Device reset request
  input wire logic oscillator_on, // Oscillator enable
  input wire logic coreTick, // Core clock tick
  input wire logic scanTick, // Scan tick
  input wire logic keypadLocked, // Keypad locked
  input wire logic logicEventReq, // Logic record request
  input wire logic inputEventReq, // Input record request
  input wire logic logicEventRecord, // Logic record
  input wire logic inputEventRecord, // Input record
  input wire logic [5:0] irqFlags, // Source flags
  input wire logic irqClearTry, // Clear attempt
  input wire logic irqOe // Interrupt asserted
);
  timeunit 1ns;
  timeprecision 10ps;

  // ----------------------------------------
  // Timing relations at the ports
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_oscOff; !oscillator_on [*3] |-> !coreTick; endproperty
  a_oscOff: assert property (p_oscOff) else $error("core tick while oscillator off");
  property p_tickGap; coreTick |=> !coreTick [*8]; endproperty
  a_tickGap: assert property (p_tickGap) else $error("core ticks too close");
  property p_scanGap; scanTick |=> !scanTick [*8]; endproperty
  a_scanGap: assert property (p_scanGap) else $error("scan ticks too close");
  property p_logicPass; logicEventReq && !keypadLocked |=> logicEventRecord; endproperty
  a_logicPass: assert property (p_logicPass) else $error("unlocked logic event lost");
  property p_logicIdle; !logicEventReq |=> !logicEventRecord; endproperty
  a_logicIdle: assert property (p_logicIdle) else $error("logic record without request");
  property p_inputPass; inputEventReq && !keypadLocked |=> inputEventRecord; endproperty
  a_inputPass: assert property (p_inputPass) else $error("unlocked input event lost");
  property p_inputIdle; !inputEventReq |=> !inputEventRecord; endproperty
  a_inputIdle: assert property (p_inputIdle) else $error("input record without request");
  property p_pinHigh; extReset_n [*4] |-> !deviceReset; endproperty
  a_pinHigh: assert property (p_pinHigh) else $error("reset request with pin high");
  property p_irqIdle; irqFlags == 6'h00 |=> !irqOe; endproperty
  a_irqIdle: assert property (p_irqIdle) else $error("interrupt with no flag set");
  property p_irqHoldOff;
    (RELEASE_CYCLES > 9) && irqClearTry && irqOe && $stable(irqFlags) ##1
      !irqOe && $stable(irqFlags) |=> !irqOe [*8];
  endproperty
  a_irqHoldOff: assert property (p_irqHoldOff) else $error("release window cut short");
endmodule // cci_core_config_asserts

// file: tb/cci_i2c_host.sv
`include "cci_defs.svh"

module cci_i2c_host (
  output logic scl, // Serial clock
  output logic sdaPull, // Pull data line low
  input wire logic sda // Resolved data line
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25; // Quarter of a 125 ns bit

  // ----------------------------------------
  // Bus primitives, clock idle high outside frames
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  task automatic bitIo(input logic b, output logic r);
    #Q sdaPull = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask

  task automatic start();
    #Q sdaPull = 1'b0;
    #Q scl = 1'b1;
    #Q sdaPull = 1'b1;
    #Q scl = 1'b0;
  endtask

  task automatic stop();
    #Q sdaPull = 1'b1;
    #Q scl = 1'b1;
    #Q sdaPull = 1'b0;
    #Q;
  endtask

  task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitIo(d[i], r[i]);
    bitIo(ackOut, ack);
  endtask

  // ----------------------------------------
  // Register write and pointer-then-read
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [2:0] acks);
    logic [7:0] r;
    start();
    xfer({`CCI_I2C_ADDR, 1'b0}, 1'b1, r, acks[2]);
    xfer(a, 1'b1, r, acks[1]);
    xfer(d, 1'b1, r, acks[0]);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [2:0] acks);
    logic [7:0] r;
    logic n;
    start();
    xfer({`CCI_I2C_ADDR, 1'b0}, 1'b1, r, acks[2]);
    xfer(a, 1'b1, r, acks[1]);
    start();
    xfer({`CCI_I2C_ADDR, 1'b1}, 1'b1, r, acks[0]);
    xfer(8'hFF, 1'b1, d, n);
    stop();
  endtask
endmodule // cci_i2c_host

// file: tb/tb.sv
`include "cci_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 10ps;
  localparam int REL = 20;
  localparam int DIVS [4] = '{20, 10, 5, 2};
  logic mclk, rst_n, extReset_n, keypadLocked, logicEventReq, inputEventReq, irqClearTry;
  logic [5:0] irqFlags;
  logic scl, hostPull, sda, sdaOe, deviceReset, oscOn, coreTick, scanTick, logRec, inRec, irqOe;
  logic [7:0] cf;
  int failCount, samplesChecked, cyc, n;

  logic sdaLvl, irqLvl, irqPin;

  // Open-drain lines with pull-ups, pulled to the level the block drives
  assign sda = !hostPull & (sdaOe ? sdaLvl : 1'b1);
  assign irqPin = irqOe ? irqLvl : 1'b1;

  cci_i2c_host i_host (.scl(scl), .sdaPull(hostPull), .sda(sda));

  cci_core_config #(.RELEASE_CYCLES(REL)) i_dut (.mclk(mclk), .rst_n(rst_n), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaLvl), .sdaOe(sdaOe), .extReset_n(extReset_n),
    .deviceReset(deviceReset), .oscillator_on(oscOn), .coreTick(coreTick),
    .scanTick(scanTick), .keypadLocked(keypadLocked), .logicEventReq(logicEventReq),
    .inputEventReq(inputEventReq), .logicEventRecord(logRec), .inputEventRecord(inRec),
    .irqFlags(irqFlags), .irqClearTry(irqClearTry), .irqOut(irqLvl), .irqOe(irqOe));

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrapUp();
    $display("compares %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] ak;
    @(negedge mclk);
    #1; // Keeps every link edge off the sampling edge
    i_host.wr(a, d, ak);
    chk(16'(ak), 16'h0000);
  endtask

  task automatic regRd(input logic [7:0] a, input logic [7:0] exp);
    logic [2:0] ak;
    logic [7:0] d;
    @(negedge mclk);
    #1; // Keeps every link edge off the sampling edge
    i_host.rd(a, d, ak);
    chk(16'({ak, d}), 16'(exp));
  endtask

  // Cycles between two pulses of a tick
  task automatic gap(input logic scan, output int m);
    m = 0;
    while (!(scan ? scanTick : coreTick) && m < 30000) begin
      @(negedge mclk);
      m++;
    end
    m = 0;
    do begin
      @(negedge mclk);
      m++;
    end while (!(scan ? scanTick : coreTick) && m < 30000);
  endtask

  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      failCount++;
      wrapUp();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {rst_n, keypadLocked, logicEventReq, inputEventReq, irqClearTry} = 5'h00;
    extReset_n = 1'b1;
    irqFlags = 6'h00;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    regRd(`CCI_ADDR_CFG, 8'h00);
    regRd(`CCI_ADDR_MASK, 8'h00);
    regWr(`CCI_ADDR_CFG, 8'h7F);
    regRd(`CCI_ADDR_CFG, 8'h7B);
    regWr(`CCI_ADDR_MASK, 8'hFF);
    regRd(`CCI_ADDR_MASK, 8'h3F);
    regWr(8'h50, 8'hA5);
    regRd(8'h50, 8'h00);
    // Core clock codes, then scan period at the fastest
    for (int c = 0; c < 4; c++) begin
      regWr(`CCI_ADDR_CFG, {1'b1, c[1:0], 5'h00});
      chk(16'(oscOn), 16'h0001);
      gap(1'b0, n);
      chk(16'(n), 16'(100 * DIVS[c]));
    end
    gap(1'b1, n);
    chk(16'(n), 16'(100 * 100 * DIVS[3]));
    regWr(`CCI_ADDR_CFG, 8'h00);
    chk(16'(oscOn), 16'h0000);
    n = 0;
    repeat (2500) begin
      @(negedge mclk);
      n += int'(coreTick);
    end
    chk(16'(n), 16'h0000);
    // Event recording while locked, each inhibit alone
    for (int k = 0; k < 6; k++) begin
      cf = (k < 2) ? 8'h00 : (k < 4) ? 8'h10 : 8'h08;
      regWr(`CCI_ADDR_CFG, cf);
      @(negedge mclk);
      keypadLocked = k[0];
      {logicEventReq, inputEventReq} = 2'b11;
      @(negedge mclk);
      {logicEventReq, inputEventReq} = 2'b00;
      chk(16'(logRec), 16'(!(k[0] & cf[4])));
      chk(16'(inRec), 16'(!(k[0] & cf[3])));
      @(negedge mclk);
      chk(16'({logRec, inRec}), 16'h0000);
    end
    keypadLocked = 1'b0;
    // Each mask bit against its own flag and all others
    for (int i = 0; i < 6; i++) begin
      regWr(`CCI_ADDR_MASK, 8'(1 << i));
      @(negedge mclk);
      irqFlags = ~6'(1 << i);
      repeat (2) @(negedge mclk);
      chk(16'({irqOe, irqPin}), 16'h0001);
      irqFlags = 6'(1 << i);
      repeat (2) @(negedge mclk);
      chk(16'({irqOe, irqPin}), 16'h0002);
    end
    // Clear attempt with a source still pending
    regWr(`CCI_ADDR_MASK, 8'h01);
    @(negedge mclk);
    irqFlags = 6'h01;
    for (int b = 0; b < 2; b++) begin
      regWr(`CCI_ADDR_CFG, b[0] ? 8'h02 : 8'h00);
      @(negedge mclk);
      irqClearTry = 1'b1;
      @(negedge mclk);
      irqClearTry = 1'b0;
      n = 0;
      while (!irqOe && n < 100) begin
        @(negedge mclk);
        n++;
      end
      chk(16'(b[0] ? (n >= REL && n <= REL + 1) : (n == 0)), 16'h0001);
    end
    // External reset pin honoured or ignored
    for (int b = 0; b < 2; b++) begin
      regWr(`CCI_ADDR_CFG, {7'h00, b[0]});
      @(negedge mclk);
      extReset_n = 1'b0;
      repeat (6) @(negedge mclk);
      chk(16'(deviceReset), 16'(!b[0]));
      extReset_n = 1'b1;
      repeat (6) @(negedge mclk);
      chk(16'(deviceReset), 16'h0000);
    end
    wrapUp();
  end
endmodule // tb

bind cci_core_config cci_core_config_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .extReset_n(extReset_n), .deviceReset(deviceReset),
  .oscillator_on(oscillator_on), .coreTick(coreTick), .scanTick(scanTick),
  .keypadLocked(keypadLocked), .logicEventReq(logicEventReq), .inputEventReq(inputEventReq),
  .logicEventRecord(logicEventRecord), .inputEventRecord(inputEventRecord),
  .irqFlags(irqFlags), .irqClearTry(irqClearTry), .irqOe(irqOe));
